// *** include/serial_port_pkg.sv ***
// Purpose: Shared constants for the dual-mode serial port
// Assumes: 50 MHz system clock
// Notes:   Register indices are word offsets on the plain register port
package serial_port_pkg;
	localparam int unsigned CLK_HZ = 50000000;
	// Baud selections, lowest to highest
	localparam int unsigned BAUD_9600   = 9600;
	localparam int unsigned BAUD_19200  = 19200;
	localparam int unsigned BAUD_38400  = 38400;
	localparam int unsigned BAUD_57600  = 57600;
	localparam int unsigned BAUD_115200 = 115200;
	localparam logic [15:0] DIV_9600   = 16'(CLK_HZ / BAUD_9600);
	localparam logic [15:0] DIV_19200  = 16'(CLK_HZ / BAUD_19200);
	localparam logic [15:0] DIV_38400  = 16'(CLK_HZ / BAUD_38400);
	localparam logic [15:0] DIV_57600  = 16'(CLK_HZ / BAUD_57600);
	localparam logic [15:0] DIV_115200 = 16'(CLK_HZ / BAUD_115200);
	// Frame: 8 data, even parity, 1 stop = 11 bit times with start
	localparam int unsigned FRAME_BITS = 11;
	// Modbus silence: 3.5 chars = 38.5 bit times, rounded up to 39
	localparam logic [7:0]  SILENCE_BITS = 8'h27;
	localparam logic [7:0]  FC_READ_HOLD  = 8'h03;
	localparam logic [7:0]  FC_WRITE_SING = 8'h06;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam int unsigned BUF_DEPTH = 16;
	// Register indices
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_CMD       = 8'h01;
	localparam logic [7:0] REG_STATUS    = 8'h02;
	localparam logic [7:0] REG_TX_LEN    = 8'h03;
	localparam logic [7:0] REG_RX_COUNT  = 8'h04;
	localparam logic [7:0] REG_SERVER_ID = 8'h05;
	localparam logic [7:0] REG_REG_ADDR  = 8'h06;
	localparam logic [7:0] REG_WR_VALUE  = 8'h07;
	localparam logic [7:0] REG_RD_RESULT = 8'h08;
	localparam logic [7:0] REG_TX_BASE   = 8'h10;
	localparam logic [7:0] REG_RX_BASE   = 8'h20;
	// CTRL fields
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_STD_BIT  = 1;
	localparam int unsigned CTRL_SLEW_BIT = 2;
	localparam int unsigned CTRL_PROT_LSB = 4;
	localparam int unsigned CTRL_RATE_LSB = 8;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	// CMD bits
	localparam int unsigned CMD_TX_BIT    = 0;
	localparam int unsigned CMD_RX_BIT    = 1;
	localparam int unsigned CMD_MB_WR_BIT = 2;
	localparam int unsigned CMD_MB_RD_BIT = 3;
	// Protocol codes
	localparam logic [1:0] PROT_ASCII  = 2'h0;
	localparam logic [1:0] PROT_BINARY = 2'h1;
	localparam logic [1:0] PROT_MODBUS = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE, ST_TX_LOAD, ST_TX_WAIT, ST_RX_WAIT, ST_MB_SILENCE, ST_MB_REPLY
	} state_t;
endpackage

// *** hdl/serial_frame_phy.sv ***
// Purpose: One 8E1 character transmitter and receiver
// Assumes: rx_i already synchronous to sys_clk_i
// Notes:   Divider is the clock count per bit
`timescale 1ns/1ps
module serial_frame_phy (
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic [15:0] div_i,
	input  wire logic        tx_go_i,
	input  wire logic [7:0]  tx_byte_i,
	output logic             tx_busy_o,
	output logic             tx_line_o,
	input  wire logic        rx_en_i,
	input  wire logic        rx_i,
	output logic             rx_valid_o,
	output logic [7:0]       rx_byte_o,
	output logic             rx_idle_tick_o
);
	logic [15:0] tx_cnt;
	logic [3:0]  tx_bit;
	logic [10:0] tx_sh;
	logic [15:0] rx_cnt;
	logic [3:0]  rx_bit;
	logic [9:0]  rx_sh;
	logic        rx_busy;
	logic [15:0] idle_cnt;
	wire         tx_tick = (tx_cnt == div_i - 16'h0001);
	wire         rx_tick = (rx_cnt == div_i - 16'h0001);
	wire         rx_mid  = (rx_cnt == {1'b0, div_i[15:1]});
	// Transmit shift: start, data lsb first, parity, stop
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_sh <= 11'h7ff; tx_bit <= 4'h0; tx_cnt <= 16'h0000; tx_busy_o <= 1'b0;
		end else if (tx_go_i && !tx_busy_o) begin
			tx_sh <= {1'b1, ^tx_byte_i, tx_byte_i, 1'b0};
			tx_bit <= 4'h0; tx_cnt <= 16'h0000; tx_busy_o <= 1'b1;
		end else if (tx_busy_o) begin
			tx_cnt <= tx_tick ? 16'h0000 : tx_cnt + 16'h0001;
			if (tx_tick) begin
				tx_sh  <= {1'b1, tx_sh[10:1]};
				tx_bit <= tx_bit + 4'h1;
				if (tx_bit == 4'(serial_port_pkg::FRAME_BITS - 1))
					tx_busy_o <= 1'b0; // Ends right as stop bit ends
			end
		end
	end
	assign tx_line_o = tx_sh[0];
	// Receive: sample mid bit, check even parity and stop
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rx_busy <= 1'b0; rx_cnt <= 16'h0000; rx_bit <= 4'h0; rx_sh <= 10'h000;
			rx_valid_o <= 1'b0; rx_byte_o <= 8'h00;
		end else begin
			rx_valid_o <= 1'b0;
			if (!rx_busy) begin
				rx_cnt <= 16'h0000; rx_bit <= 4'h0;
				if (rx_en_i && !rx_i) rx_busy <= 1'b1;
			end else begin
				rx_cnt <= rx_tick ? 16'h0000 : rx_cnt + 16'h0001;
				if (rx_mid) begin
					rx_sh  <= {rx_i, rx_sh[9:1]};
					rx_bit <= rx_bit + 4'h1;
					if (rx_bit == 4'(serial_port_pkg::FRAME_BITS - 1)) begin
						rx_busy <= 1'b0;
						// Drop characters with bad parity or framing
						if (rx_i && (^rx_sh[9:1] == 1'b0)) begin
							rx_valid_o <= 1'b1;
							rx_byte_o  <= rx_sh[8:1];
						end
					end
				end
			end
		end
	end
	// One pulse per idle bit time, used for Modbus silence
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			idle_cnt <= 16'h0000; rx_idle_tick_o <= 1'b0;
		end else begin
			rx_idle_tick_o <= 1'b0;
			if (rx_busy || !rx_i) idle_cnt <= 16'h0000;
			else if (idle_cnt == div_i - 16'h0001) begin
				idle_cnt <= 16'h0000; rx_idle_tick_o <= 1'b1;
			end else idle_cnt <= idle_cnt + 16'h0001;
		end
	end
endmodule

// *** hdl/dual_mode_serial_port.sv ***
// Function
// - Baud rate selectable from 9600 up to 115200.
// - Frames carry eight data bits, even parity, one stop bit.
// - Mode setting picks RS232 or RS485 transceiver.
// - RS232 full duplex; RS485 one direction at a time.
// - Slow/fast edge setting applies only in RS485 mode.
// - ASCII protocol sends zero-terminated strings and receives by count, in both modes.
// - Modbus client offered only in RS485 mode.
// - Only function codes 0x03 and 0x06 supported.
// - Requests go to software-set server identifier.
// - Requests use software-set register address.
// - Write sends write value; read result shown read-only.
// - Binary protocol moves raw bytes in both modes.
// - Binary write sends exactly the set length from buffer.
// - Binary read moves read count bytes, at most 16, into read buffer.
// - ASCII read fetches count bytes, at most 16, into text read buffer.
// - ASCII write sends text write buffer on the line.
// - No drive or receive unless port enabled.
//
// Purpose: Dual-mode serial port with text, raw and Modbus client
// Assumes: Register port with one-cycle read latency
// Notes:   Text and raw buffers share storage; one command at a time
`timescale 1ns/1ps
module dual_mode_serial_port (
	input  wire logic        sys_clk_i,
	input  wire logic        rstn_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [31:0]      rdata_o,
	input  wire logic        rx_i,
	output logic             tx_o,
	output logic             tx_oe_o,
	output logic             rx_en_o,
	output logic             rs485_sel_o,
	output logic             slew_slow_o
);
	logic [31:0] ctrl;
	logic [7:0]  tx_len;
	logic [7:0]  rx_count;
	logic [7:0]  server_id;
	logic [15:0] reg_addr;
	logic [15:0] wr_value;
	logic [15:0] rd_result;
	logic [7:0]  tx_mem [serial_port_pkg::BUF_DEPTH];
	logic [7:0]  rx_mem [serial_port_pkg::BUF_DEPTH];
	serial_port_pkg::state_t state;
	logic [7:0]  idx;
	logic [7:0]  total;
	logic [7:0]  sil_cnt;
	logic [15:0] crc;
	logic        tx_go;
	logic [7:0]  tx_byte;
	logic        error;
	logic        phy_busy;
	logic        phy_line;
	logic        phy_valid;
	logic [7:0]  phy_byte;
	logic        idle_tick;
	logic [7:0]  mb_frame [8];

	// CRC-16 byte update, reflected polynomial
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ((r >> 1) ^ serial_port_pkg::CRC_POLY) : (r >> 1);
		return r;
	endfunction

	// Control field decode
	wire       enable   = ctrl[serial_port_pkg::CTRL_EN_BIT];
	wire       rs485    = ctrl[serial_port_pkg::CTRL_STD_BIT];
	wire [1:0] protocol = ctrl[serial_port_pkg::CTRL_PROT_LSB +: 2];
	wire [2:0] rate_sel = ctrl[serial_port_pkg::CTRL_RATE_LSB +: 3];
	wire       modbus_ok = rs485 && protocol == serial_port_pkg::PROT_MODBUS;
	wire       is_reg    = wr_i && addr_i < serial_port_pkg::REG_TX_BASE;
	wire       tx_win    = addr_i >= serial_port_pkg::REG_TX_BASE && addr_i < serial_port_pkg::REG_RX_BASE;
	wire       rx_win    = addr_i >= serial_port_pkg::REG_RX_BASE &&
	                       addr_i < 8'(serial_port_pkg::REG_RX_BASE + serial_port_pkg::BUF_DEPTH);
	wire       cmd_wr    = wr_i && addr_i == serial_port_pkg::REG_CMD && state == serial_port_pkg::ST_IDLE && enable;
	wire       idle      = state == serial_port_pkg::ST_IDLE;

	// Rate table, out-of-range choices clamp to the top rate
	wire [15:0] divider =
		(rate_sel == 3'h0) ? serial_port_pkg::DIV_9600  :
		(rate_sel == 3'h1) ? serial_port_pkg::DIV_19200 :
		(rate_sel == 3'h2) ? serial_port_pkg::DIV_38400 :
		(rate_sel == 3'h3) ? serial_port_pkg::DIV_57600 : serial_port_pkg::DIV_115200;

	// Driver enable for the next cycle; receive follows it so the two never overlap in RS485 mode
	wire drive_next = enable && (rs485 ? (phy_busy || tx_go) : 1'b1);
	wire rx_allowed = enable && !(rs485 && drive_next);

	serial_frame_phy u_phy (
		.sys_clk_i      (sys_clk_i),
		.rstn_i         (rstn_i),
		.div_i          (divider),
		.tx_go_i        (tx_go),
		.tx_byte_i      (tx_byte),
		.tx_busy_o      (phy_busy),
		.tx_line_o      (phy_line),
		.rx_en_i        (rx_allowed),
		.rx_i           (rx_i),
		.rx_valid_o     (phy_valid),
		.rx_byte_o      (phy_byte),
		.rx_idle_tick_o (idle_tick)
	);

	// Modbus request image: id, code, addr, data/count; CRC appended live
	always_comb begin
		mb_frame[0] = server_id;
		mb_frame[1] = 8'h00;
		mb_frame[2] = reg_addr[15:8];
		mb_frame[3] = reg_addr[7:0];
		mb_frame[4] = 8'h00;
		mb_frame[5] = 8'h01;
		mb_frame[6] = crc[7:0];
		mb_frame[7] = crc[15:8];
		if (total == 8'h01) begin
			mb_frame[1] = serial_port_pkg::FC_WRITE_SING;
			mb_frame[4] = wr_value[15:8];
			mb_frame[5] = wr_value[7:0];
		end else begin
			mb_frame[1] = serial_port_pkg::FC_READ_HOLD;
		end
	end

	// Byte source for transmit by protocol
	always_comb begin
		tx_byte = tx_mem[idx[3:0]];
		if (protocol == serial_port_pkg::PROT_MODBUS)
			tx_byte = mb_frame[idx[2:0]];
	end

	// Settings writes; read result written only by the client
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl <= serial_port_pkg::CTRL_RESET;
			tx_len <= 8'h00; rx_count <= 8'h00; server_id <= 8'h00;
			reg_addr <= 16'h0000; wr_value <= 16'h0000;
		end else if (is_reg) begin
			if (addr_i == serial_port_pkg::REG_CTRL) ctrl <= wdata_i;
			else if (addr_i == serial_port_pkg::REG_TX_LEN) tx_len <= wdata_i[7:0];
			else if (addr_i == serial_port_pkg::REG_RX_COUNT) rx_count <= wdata_i[7:0];
			else if (addr_i == serial_port_pkg::REG_SERVER_ID) server_id <= wdata_i[7:0];
			else if (addr_i == serial_port_pkg::REG_REG_ADDR) reg_addr <= wdata_i[15:0];
			else if (addr_i == serial_port_pkg::REG_WR_VALUE) wr_value <= wdata_i[15:0];
		end
	end

	// Shared write buffer for text and raw data
	always_ff @(posedge sys_clk_i) begin
		if (wr_i && tx_win) tx_mem[addr_i[3:0]] <= wdata_i[7:0];
	end

	// Command engine
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= serial_port_pkg::ST_IDLE; idx <= 8'h00; total <= 8'h00;
			sil_cnt <= 8'h00; crc <= serial_port_pkg::CRC_INIT; tx_go <= 1'b0;
			rd_result <= 16'h0000; error <= 1'b0;
		end else begin
			tx_go <= 1'b0;
			if (!enable && !idle) begin
				state <= serial_port_pkg::ST_IDLE;
			end else case (state)
			serial_port_pkg::ST_IDLE: begin
				idx <= 8'h00; crc <= serial_port_pkg::CRC_INIT; sil_cnt <= 8'h00;
				if (cmd_wr) begin
					error <= 1'b0;
					if (wdata_i[serial_port_pkg::CMD_TX_BIT] && protocol != serial_port_pkg::PROT_MODBUS) begin
						// Raw: fixed length; text: until zero byte
						total <= (protocol == serial_port_pkg::PROT_BINARY) ? tx_len : 8'(serial_port_pkg::BUF_DEPTH);
						state <= serial_port_pkg::ST_TX_LOAD;
					end else if (wdata_i[serial_port_pkg::CMD_RX_BIT] && protocol != serial_port_pkg::PROT_MODBUS) begin
						total <= (rx_count > 8'(serial_port_pkg::BUF_DEPTH)) ? 8'(serial_port_pkg::BUF_DEPTH) : rx_count;
						state <= serial_port_pkg::ST_RX_WAIT;
					end else if ((wdata_i[serial_port_pkg::CMD_MB_WR_BIT] || wdata_i[serial_port_pkg::CMD_MB_RD_BIT])
					             && modbus_ok) begin
						total <= wdata_i[serial_port_pkg::CMD_MB_WR_BIT] ? 8'h01 : 8'h00;
						state <= serial_port_pkg::ST_MB_SILENCE;
					end else error <= 1'b1;
				end
			end
			serial_port_pkg::ST_MB_SILENCE: begin
				// Line must be quiet 3.5 chars before a request
				if (idle_tick) sil_cnt <= sil_cnt + 8'h01;
				if (sil_cnt == serial_port_pkg::SILENCE_BITS) state <= serial_port_pkg::ST_TX_LOAD;
			end
			serial_port_pkg::ST_TX_LOAD: begin
				if (protocol == serial_port_pkg::PROT_MODBUS && idx == 8'h08) begin
					idx <= 8'h00; crc <= serial_port_pkg::CRC_INIT;
					state <= serial_port_pkg::ST_MB_REPLY;
				end else if (protocol != serial_port_pkg::PROT_MODBUS &&
				             (idx == total || (protocol == serial_port_pkg::PROT_ASCII && idx != 8'h00 &&
				              tx_mem[4'(idx - 8'h01)] == 8'h00))) begin
					state <= serial_port_pkg::ST_IDLE;
				end else begin
					tx_go <= 1'b1;
					state <= serial_port_pkg::ST_TX_WAIT;
				end
			end
			serial_port_pkg::ST_TX_WAIT: begin
				if (!tx_go && !phy_busy) begin
					if (idx < 8'h06) crc <= crc_step(crc, tx_byte);
					idx <= idx + 8'h01;
					state <= serial_port_pkg::ST_TX_LOAD;
				end
			end
			serial_port_pkg::ST_RX_WAIT: begin
				if (idx == total) state <= serial_port_pkg::ST_IDLE;
				else if (phy_valid) idx <= idx + 8'h01;
			end
			serial_port_pkg::ST_MB_REPLY: begin
				// Reply: id, code, then read count+data or echo, then CRC
				if (phy_valid) begin
					idx <= idx + 8'h01;
					crc <= crc_step(crc, phy_byte);
					if (total == 8'h00 && idx == 8'h03) rd_result[15:8] <= phy_byte;
					if (total == 8'h00 && idx == 8'h04) rd_result[7:0]  <= phy_byte;
					if (idx == ((total == 8'h00) ? 8'h06 : 8'h07)) begin
						error <= (crc_step(crc, phy_byte) != 16'h0000);
						state <= serial_port_pkg::ST_IDLE;
					end
				end else if (sil_cnt == serial_port_pkg::SILENCE_BITS && idx != 8'h00) begin
					error <= 1'b1; state <= serial_port_pkg::ST_IDLE;
				end
				if (phy_valid) sil_cnt <= 8'h00;
				else if (idle_tick && idx != 8'h00) sil_cnt <= sil_cnt + 8'h01;
			end
			default: state <= serial_port_pkg::ST_IDLE;
			endcase
		end
	end

	// Received bytes land in the shared read buffer
	always_ff @(posedge sys_clk_i) begin
		if (state == serial_port_pkg::ST_RX_WAIT && phy_valid && idx != total)
			rx_mem[idx[3:0]] <= phy_byte;
	end

	// Line pins; RS485 driver only during a character
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_o <= 1'b1; tx_oe_o <= 1'b0; rx_en_o <= 1'b0; rs485_sel_o <= 1'b0; slew_slow_o <= 1'b0;
		end else begin
			tx_o        <= phy_line || !drive_next; // Idle level whenever released, even on abort
			tx_oe_o     <= drive_next;
			rx_en_o     <= rx_allowed;
			rs485_sel_o <= rs485;
			slew_slow_o <= rs485 && !ctrl[serial_port_pkg::CTRL_SLEW_BIT];
		end
	end

	// Register read, data in the cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) rdata_o <= 32'h0000_0000;
		else if (!rd_i) rdata_o <= 32'h0000_0000;
		else if (addr_i == serial_port_pkg::REG_CTRL) rdata_o <= ctrl;
		else if (addr_i == serial_port_pkg::REG_STATUS) rdata_o <= {16'h0, idx, 3'h0, error, 3'h0, !idle};
		else if (addr_i == serial_port_pkg::REG_TX_LEN) rdata_o <= {24'h0, tx_len};
		else if (addr_i == serial_port_pkg::REG_RX_COUNT) rdata_o <= {24'h0, rx_count};
		else if (addr_i == serial_port_pkg::REG_SERVER_ID) rdata_o <= {24'h0, server_id};
		else if (addr_i == serial_port_pkg::REG_REG_ADDR) rdata_o <= {16'h0, reg_addr};
		else if (addr_i == serial_port_pkg::REG_WR_VALUE) rdata_o <= {16'h0, wr_value};
		else if (addr_i == serial_port_pkg::REG_RD_RESULT) rdata_o <= {16'h0, rd_result};
		else if (tx_win) rdata_o <= {24'h0, tx_mem[addr_i[3:0]]};
		else if (rx_win) rdata_o <= {24'h0, rx_mem[addr_i[3:0]]};
		else rdata_o <= 32'h0000_0000;
	end
endmodule

// *** verification/serial_port_sva.sv ***
// Purpose: Port-level assertions for the dual-mode serial port
// Assumes: Single clock domain, async active-low reset
// Notes:   Bit width check allows one clock of slack at 115200
`timescale 1ns/1ps
module serial_port_sva (
	input wire logic        sys_clk_i,
	input wire logic        rstn_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        rx_i,
	input wire logic        tx_o,
	input wire logic        tx_oe_o,
	input wire logic        rx_en_o,
	input wire logic        rs485_sel_o,
	input wire logic        slew_slow_o
);
	localparam int MIN_BIT = 433; // Fastest rate, minus rounding slack
	logic [9:0] since_edge;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	// Age of the current line level, saturating so slow rates never wrap
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			since_edge <= 10'h3ff;
		end else if ($changed(tx_o)) begin
			since_edge <= 10'h001;
		end else if (since_edge != 10'h3ff) begin
			since_edge <= since_edge + 10'h001;
		end
	end
	a_bit_min_width: assert property (tx_oe_o && $changed(tx_o) |-> since_edge >= MIN_BIT)
		else $error("transmit bit shorter than one bit time");
	a_slew_rs485_only: assert property (slew_slow_o |-> rs485_sel_o)
		else $error("slow edges outside rs485 mode");
	a_enable_gates_drive: assert property (tx_oe_o |-> rx_en_o != rs485_sel_o)
		else $error("receiver enable wrong while line driven");
	a_rs232_full_duplex: assert property (rx_en_o && !rs485_sel_o |-> tx_oe_o)
		else $error("rs232 driver not held on");
	a_idle_when_released: assert property (!tx_oe_o |-> tx_o)
		else $error("transmit data active while released");
	a_release_after_stop: assert property (rs485_sel_o && $fell(tx_oe_o) |-> tx_o && $past(tx_o, 2))
		else $error("driver released before stop bit ended");
	a_rs485_start_bit: assert property (rs485_sel_o && $rose(tx_oe_o) |-> ##[0:2] !tx_o)
		else $error("driver on without a start bit");
	a_read_answer_once: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside the answer cycle");
	a_unmapped_reads_zero: assert property (rd_i && addr_i == 8'h09 |=> rdata_o == 32'h0)
		else $error("unmapped index read nonzero");
	c_rs485_frame: cover property (rs485_sel_o && $rose(tx_oe_o));
	c_rs232_frame: cover property (!rs485_sel_o && tx_oe_o && $fell(tx_o));
	c_read_data: cover property (rd_i ##1 rdata_o != 32'h0);
endmodule
bind dual_mode_serial_port serial_port_sva sva (.sys_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.rx_i, .tx_o, .tx_oe_o, .rx_en_o, .rs485_sel_o, .slew_slow_o);

// *** verification/serial_peer.sv ***
// Purpose: Behavioural external serial device on the line pins
// Assumes: Line idles high through bias resistors
// Notes:   Bad frames are counted, never stored
`timescale 1ns/1ps
module serial_peer #(
	parameter int BIT = 434
) (
	input  wire logic sys_clk_i,
	input  wire logic tx_i,
	input  wire logic oe_i,
	output logic      rx_o
);
	logic [7:0] got[$];
	int         bad_frames;
	logic [9:0] v;
	logic       start_ok;
	initial begin
		rx_o = 1'b1;
		bad_frames = 0;
	end
	// Mid-cell sampling; only a driven line can start a frame
	always begin
		@(negedge tx_i iff oe_i);
		repeat (BIT / 2) @(posedge sys_clk_i);
		start_ok = !tx_i;
		for (int i = 0; i < 10; i++) begin
			repeat (BIT) @(posedge sys_clk_i);
			v[i] = tx_i;
		end
		if (start_ok && !(^v[8:0]) && v[9]) begin
			got.push_back(v[7:0]);
		end else begin
			bad_frames++;
		end
	end
	// Start, data LSB first, even parity (flip spoils it), stop
	task automatic send(input logic [7:0] b, input logic flip);
		logic [10:0] f;
		f = {1'b1, ^b ^ flip, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rx_o <= f[i];
			repeat (BIT) @(posedge sys_clk_i);
		end
	endtask
endmodule

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the dual-mode serial port
// Assumes: Peer model stands on the line pins
// Notes:   Line traffic runs at 115200 to keep the run short
`timescale 1ns/1ps
module tb;
	localparam int BIT = 434; // Clocks per bit at 115200
	logic        sys_clk_i;
	logic        rstn_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	logic        rx_i;
	logic        tx_o;
	logic        tx_oe_o;
	logic        rx_en_o;
	logic        rs485_sel_o;
	logic        slew_slow_o;
	logic [7:0]  exp_q[$];
	logic [15:0] crc;
	int          miscompares;
	int          comparisons;
	dual_mode_serial_port dut (.sys_clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_i, .tx_o,
		.tx_oe_o, .rx_en_o, .rs485_sel_o, .slew_slow_o);
	serial_peer #(.BIT(BIT)) peer (.sys_clk_i, .tx_i(tx_o), .oe_i(tx_oe_o), .rx_o(rx_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 check(rdata_o, e);
	endtask
	task automatic mode(input logic [31:0] c, input logic [3:0] e);
		wr(serial_port_pkg::REG_CTRL, c);
		@(posedge sys_clk_i);
		#1 check(32'({rs485_sel_o, slew_slow_o, rx_en_o, tx_oe_o}), {28'h0, e});
	endtask
	// Bounded wait for the peer to collect n characters
	task automatic wait_bytes(input int n);
		int k;
		k = 0;
		while (peer.got.size() < n && k < 70000) begin
			@(posedge sys_clk_i);
			k++;
		end
		check(32'(peer.got.size()), 32'(n));
	endtask
	task automatic t_reset;
		check(32'({tx_o, tx_oe_o, rx_en_o, rs485_sel_o, slew_slow_o}), 32'h10);
		rd(8'h09, 32'h0);
	endtask
	task automatic t_modes;
		mode(32'h3, 4'he);
		mode(32'h1, 4'h3);
		mode(32'h7, 4'ha);
	endtask
	task automatic t_raw_tx;
		wr(serial_port_pkg::REG_TX_BASE, 32'ha5);
		wr(serial_port_pkg::REG_TX_BASE + 8'h01, 32'h3c);
		wr(serial_port_pkg::REG_TX_BASE + 8'h02, 32'hff);
		wr(serial_port_pkg::REG_TX_LEN, 32'h2);
		wr(serial_port_pkg::REG_CTRL, 32'h417);
		peer.got.delete();
		wr(serial_port_pkg::REG_CMD, 32'h1);
		wait_bytes(2);
		repeat (2 * BIT) @(posedge sys_clk_i);
		check(32'(tx_oe_o), 32'h0);
		check(32'(peer.got[0]), 32'ha5);
		check(32'(peer.got[1]), 32'h3c);
	endtask
	task automatic t_text_tx;
		wr(serial_port_pkg::REG_TX_BASE, 32'h48);
		wr(serial_port_pkg::REG_TX_BASE + 8'h01, 32'h69);
		wr(serial_port_pkg::REG_TX_BASE + 8'h02, 32'h00);
		wr(serial_port_pkg::REG_TX_BASE + 8'h03, 32'h58);
		wr(serial_port_pkg::REG_CTRL, 32'h401);
		peer.got.delete();
		wr(serial_port_pkg::REG_CMD, 32'h1);
		wait_bytes(3);
		repeat (2 * BIT) @(posedge sys_clk_i);
		check(32'(tx_o), 32'h1);
		check(32'(peer.got[2]), 32'h0);
		check(peer.bad_frames, 32'h0);
	endtask
	// A spoilt-parity character must be dropped before the good ones
	task automatic t_raw_rx;
		wr(serial_port_pkg::REG_CTRL, 32'h411);
		wr(serial_port_pkg::REG_RX_COUNT, 32'h2);
		wr(serial_port_pkg::REG_CMD, 32'h2);
		peer.send(8'h11, 1'b1);
		peer.send(8'h5a, 1'b0);
		peer.send(8'hc3, 1'b0);
		repeat (BIT) @(posedge sys_clk_i);
		rd(serial_port_pkg::REG_RX_BASE, 32'h5a);
		rd(serial_port_pkg::REG_RX_BASE + 8'h01, 32'hc3);
	endtask
	task automatic t_modbus;
		wr(serial_port_pkg::REG_SERVER_ID, 32'h11);
		wr(serial_port_pkg::REG_REG_ADDR, 32'h0102);
		wr(serial_port_pkg::REG_WR_VALUE, 32'hbeef);
		wr(serial_port_pkg::REG_CTRL, 32'h427);
		peer.got.delete();
		wr(serial_port_pkg::REG_CMD, 32'h4);
		wait_bytes(8);
		exp_q = '{8'h11, 8'h06, 8'h01, 8'h02, 8'hbe, 8'hef};
		crc = serial_port_pkg::CRC_INIT;
		foreach (exp_q[i]) begin
			crc ^= {8'h00, exp_q[i]};
			repeat (8) crc = crc[0] ? (crc >> 1) ^ serial_port_pkg::CRC_POLY : crc >> 1;
		end
		exp_q.push_back(crc[7:0]);
		exp_q.push_back(crc[15:8]);
		foreach (exp_q[i]) check(32'(peer.got[i]), 32'(exp_q[i]));
		wr(serial_port_pkg::REG_CTRL, 32'h0);
		@(posedge sys_clk_i);
		#1 check(32'({tx_oe_o, rx_en_o}), 32'h0);
	endtask
	task automatic complete_run;
		$display("comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Whole sequence needs about 96k cycles; limit keeps a hang inside the budget
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		miscompares++;
		complete_run();
	end
	initial begin
		rstn_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		miscompares = 0;
		comparisons = 0;
		repeat (2) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		#1 t_reset();
		t_modes();
		t_raw_tx();
		t_text_tx();
		t_raw_rx();
		t_modbus();
		complete_run();
	end
endmodule
